//--- cg_control.v
// codec control registers: input gain, port alignment, interrupts, mute and general pins
//
// Function
// - separate left/right input gain, 1 dB steps
// - gain field is signed 6-bit, top bits reserved
// - sync bit forces port clock phase alignment
// - forced lock picks emphasis filter by code
// - interrupt pin style high, low or open-drain
// - status bit set once condition seen since read
// - reading status clears every status bit not hit by an event that cycle
// - masked source reads zero, never moves pin
// - pll loss sets status bit seven
// - adc over-range sets status bit one
// - mode code from high and low registers
// - mode: arrival, removal or level while present
// - pin active level only from style field
// - mute indicator polarity bit picks active level
// - mute indicator active when all mapped muted
// - nothing mapped holds mute indicator active
// - general pin role: mute, low/overflow, high
// - plain low is driven, overflow is open-drain
// - overflow indicator follows left or right over-range
// - mute role uses pin polarity bit
// - polarity ignored in low/overflow and high roles
// - drive-high role drives pin constantly high
// - function bits 00 drive low, 11 overflow
`timescale 1ns/1ps
`include "cg_defines.vh"

module cg_control (
  input wire CLK_SYS,
  input wire RST,
  input wire [7:0] REG_ADDR,
  input wire REG_WR,
  input wire [7:0] REG_WDATA,
  input wire REG_RD,
  output reg [7:0] REG_RDATA,
  output reg REG_RVALID,
  input wire PLL_LOCKED,
  input wire ADC_OVR_LEFT,
  input wire ADC_OVR_RIGHT,
  input wire [5:0] CHANNEL_MUTE,
  input wire FORCED_LOCK_ENABLE,
  input wire [1:0] SOFT_ZERO_CROSS_SEL,
  input wire ZERO_CROSS,
  input wire RAMP_TICK,
  output wire [5:0] LEFT_INPUT_GAIN,
  output wire [5:0] RIGHT_INPUT_GAIN,
  output reg PORT_PHASE_ALIGN,
  output reg [1:0] EMPHASIS_FILTER_SEL,
  output reg IRQ_PIN_O,
  output reg IRQ_PIN_OE,
  output reg MUTE_INDICATOR,
  output reg [6:0] GENERAL_OUTPUT_PIN_O,
  output reg [6:0] GENERAL_OUTPUT_PIN_OE
);

  // and of the channel mutes that a 4-bit map selects; pairs share a bit
  function mapped_mute;
    input [3:0] map;
    input [5:0] mutes;
    begin
      mapped_mute = (~map[3] | mutes[0]) &
                    (~map[2] | mutes[1]) &
                    (~map[1] | (mutes[2] & mutes[3])) &
                    (~map[0] | (mutes[4] & mutes[5]));
    end
  endfunction

  reg [5:0] left_gain_reg;
  reg [5:0] right_gain_reg;
  reg [7:0] ctrl_reg;
  reg [7:0] status_reg;
  reg [7:0] status_next;
  reg [7:0] mask_reg;
  reg [7:0] mode_hi_reg;
  reg [7:0] mode_lo_reg;
  reg [7:0] mute_ctrl_reg;
  reg [7:0] gp_ctrl_reg [0:6];
  reg [7:0] cond_prev_reg;
  reg [7:0] rdata_next;
  reg lock_meta_reg;
  reg lock_sync_reg;
  reg ovr_l_meta_reg;
  reg ovr_l_sync_reg;
  reg ovr_r_meta_reg;
  reg ovr_r_sync_reg;

  wire [7:0] cond;
  wire [7:0] rise;
  wire [7:0] fall;
  wire [7:0] event_hit;
  wire [7:0] level_mode;
  wire [7:0] edge_mode;
  wire irq_active;
  wire mute_active;
  wire over_range;
  wire status_read;
  wire [1:0] style;
  wire [2:0] gp_index;
  wire gp_hit;

  // two-flop synchronisers for the pll lock and the over-range flags
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      lock_meta_reg <= 1'b1;
      lock_sync_reg <= 1'b1;
      ovr_l_meta_reg <= 1'b0;
      ovr_l_sync_reg <= 1'b0;
      ovr_r_meta_reg <= 1'b0;
      ovr_r_sync_reg <= 1'b0;
    end else begin
      lock_meta_reg <= PLL_LOCKED;
      lock_sync_reg <= lock_meta_reg;
      ovr_l_meta_reg <= ADC_OVR_LEFT;
      ovr_l_sync_reg <= ovr_l_meta_reg;
      ovr_r_meta_reg <= ADC_OVR_RIGHT;
      ovr_r_sync_reg <= ovr_r_meta_reg;
    end
  end

  // over-range on either channel path
  assign over_range = ovr_l_sync_reg | ovr_r_sync_reg;

  // condition vector, sources at their status bit positions
  assign cond = {~lock_sync_reg, 5'h00, over_range, 1'b0};

  // per-source mode code and edge detection
  assign rise = cond & ~cond_prev_reg;
  assign fall = ~cond & cond_prev_reg;
  assign level_mode = mode_hi_reg & ~mode_lo_reg & `CG_SRC_MASK;
  assign edge_mode = ~mode_hi_reg & `CG_SRC_MASK;
  assign event_hit = ((~mode_hi_reg & ~mode_lo_reg & rise) |
                      (~mode_hi_reg & mode_lo_reg & fall) |
                      (level_mode & cond)) & mask_reg & `CG_SRC_MASK;

  // register decode
  assign status_read = REG_RD && (REG_ADDR == `CG_ADDR_IRQ_STATUS);
  assign gp_hit = (REG_ADDR >= `CG_ADDR_GP_FIRST) && (REG_ADDR <= `CG_ADDR_GP_LAST);
  assign gp_index = REG_ADDR[2:0] - 3'h1;

  // sticky status: read clears, a new event in the same cycle still sets
  always @* begin
    status_next = status_reg;
    if (status_read) begin
      status_next = 8'h00;
    end
    status_next = (status_next | event_hit) & mask_reg & `CG_SRC_MASK;
  end

  // condition history and status register
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cond_prev_reg <= 8'h00;
      status_reg <= 8'h00;
    end else begin
      cond_prev_reg <= cond;
      status_reg <= status_next;
    end
  end

  // host writes to the configuration registers
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      left_gain_reg <= `CG_RST_GAIN;
      right_gain_reg <= `CG_RST_GAIN;
      ctrl_reg <= `CG_RST_IRQ_CTRL;
      mask_reg <= `CG_RST_IRQ_MASK;
      mode_hi_reg <= `CG_RST_IRQ_MODE;
      mode_lo_reg <= `CG_RST_IRQ_MODE;
      mute_ctrl_reg <= `CG_RST_MUTE_CTRL;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `CG_ADDR_LEFT_GAIN: left_gain_reg <= REG_WDATA[`CG_GAIN_MSB:0];
        `CG_ADDR_RIGHT_GAIN: right_gain_reg <= REG_WDATA[`CG_GAIN_MSB:0];
        `CG_ADDR_IRQ_CTRL: ctrl_reg <= REG_WDATA & `CG_CTRL_WMASK;
        `CG_ADDR_IRQ_MASK: mask_reg <= REG_WDATA & `CG_SRC_MASK;
        `CG_ADDR_IRQ_MODE_HI: mode_hi_reg <= REG_WDATA & `CG_SRC_MASK;
        `CG_ADDR_IRQ_MODE_LO: mode_lo_reg <= REG_WDATA & `CG_SRC_MASK;
        `CG_ADDR_MUTE_CTRL: mute_ctrl_reg <= REG_WDATA & `CG_MUTE_WMASK;
        default: begin
        end
      endcase
    end
  end

  // general pin control registers, one per pin
  genvar g;
  generate
    for (g = 0; g < `CG_GP_COUNT; g = g + 1) begin : gp_regs
      always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
          gp_ctrl_reg[g] <= `CG_RST_GP_CTRL;
        end else if (REG_WR && gp_hit && (gp_index == g)) begin
          gp_ctrl_reg[g] <= REG_WDATA;
        end
      end
    end
  endgenerate

  // read multiplexer; unmapped addresses read zero
  always @* begin
    rdata_next = 8'h00;
    case (REG_ADDR)
      `CG_ADDR_LEFT_GAIN: rdata_next = {2'b00, left_gain_reg};
      `CG_ADDR_RIGHT_GAIN: rdata_next = {2'b00, right_gain_reg};
      `CG_ADDR_IRQ_CTRL: rdata_next = ctrl_reg;
      `CG_ADDR_IRQ_STATUS: rdata_next = status_reg & mask_reg;
      `CG_ADDR_IRQ_MASK: rdata_next = mask_reg;
      `CG_ADDR_IRQ_MODE_HI: rdata_next = mode_hi_reg;
      `CG_ADDR_IRQ_MODE_LO: rdata_next = mode_lo_reg;
      `CG_ADDR_MUTE_CTRL: rdata_next = mute_ctrl_reg;
      default: begin
        if (gp_hit) begin
          rdata_next = gp_ctrl_reg[gp_index];
        end
      end
    endcase
  end

  // read data and its one-cycle valid strobe
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= rdata_next;
      end
    end
  end

  // applied gains follow the programmed values per soft/zero-cross mode
  cg_gain_stepper left_step (
    .clk(CLK_SYS),
    .rst(RST),
    .target(left_gain_reg),
    .szc_sel(SOFT_ZERO_CROSS_SEL),
    .zero_cross(ZERO_CROSS),
    .ramp_tick(RAMP_TICK),
    .applied_reg(LEFT_INPUT_GAIN)
  );

  cg_gain_stepper right_step (
    .clk(CLK_SYS),
    .rst(RST),
    .target(right_gain_reg),
    .szc_sel(SOFT_ZERO_CROSS_SEL),
    .zero_cross(ZERO_CROSS),
    .ramp_tick(RAMP_TICK),
    .applied_reg(RIGHT_INPUT_GAIN)
  );

  // pending edge-mode status or a live unmasked level condition
  assign irq_active = |(status_reg & edge_mode) | |(cond & level_mode & mask_reg);
  assign style = ctrl_reg[`CG_CTRL_STYLE_MSB:`CG_CTRL_STYLE_LSB];

  // all mapped mutes present; an empty map gives active
  assign mute_active = mapped_mute(mute_ctrl_reg[`CG_MUTE_MAP_MSB:`CG_MUTE_MAP_LSB],
                                   CHANNEL_MUTE);

  // port controls, interrupt pin and mute indicator
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PORT_PHASE_ALIGN <= 1'b0;
      EMPHASIS_FILTER_SEL <= 2'b00;
      IRQ_PIN_O <= 1'b0;
      IRQ_PIN_OE <= 1'b1;
      MUTE_INDICATOR <= 1'b0;
    end else begin
      PORT_PHASE_ALIGN <= ctrl_reg[`CG_CTRL_ALIGN_BIT];
      EMPHASIS_FILTER_SEL <= FORCED_LOCK_ENABLE ?
                             ctrl_reg[`CG_CTRL_EMPH_MSB:`CG_CTRL_EMPH_LSB] : 2'b00;
      case (style)
        `CG_STYLE_HIGH: begin
          IRQ_PIN_O <= irq_active;
          IRQ_PIN_OE <= 1'b1;
        end
        `CG_STYLE_LOW: begin
          IRQ_PIN_O <= ~irq_active;
          IRQ_PIN_OE <= 1'b1;
        end
        `CG_STYLE_OPEN_DRAIN: begin
          IRQ_PIN_O <= 1'b0;
          IRQ_PIN_OE <= irq_active;
        end
        default: begin
          IRQ_PIN_O <= 1'b0;
          IRQ_PIN_OE <= 1'b0;
        end
      endcase
      MUTE_INDICATOR <= mute_ctrl_reg[`CG_MUTE_LEVEL_BIT] ? mute_active : ~mute_active;
    end
  end

  // general pins, each decoded from its own role, polarity and function bits
  generate
    for (g = 0; g < `CG_GP_COUNT; g = g + 1) begin : gp_pins
      wire [1:0] role;
      wire pin_mute;
      assign role = gp_ctrl_reg[g][`CG_GP_ROLE_MSB:`CG_GP_ROLE_LSB];
      assign pin_mute = mapped_mute(gp_ctrl_reg[g][4:1], CHANNEL_MUTE);
      always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
          GENERAL_OUTPUT_PIN_O[g] <= 1'b0;
          GENERAL_OUTPUT_PIN_OE[g] <= 1'b0;
        end else begin
          case (role)
            `CG_ROLE_MUTE: begin
              GENERAL_OUTPUT_PIN_O[g] <= gp_ctrl_reg[g][`CG_GP_LEVEL_BIT] ?
                                         pin_mute : ~pin_mute;
              GENERAL_OUTPUT_PIN_OE[g] <= 1'b1;
            end
            `CG_ROLE_LOW_OVR: begin
              GENERAL_OUTPUT_PIN_O[g] <= 1'b0;
              if (gp_ctrl_reg[g][1:0] == 2'b00) begin
                GENERAL_OUTPUT_PIN_OE[g] <= 1'b1;
              end else if (gp_ctrl_reg[g][1:0] == 2'b11) begin
                GENERAL_OUTPUT_PIN_OE[g] <= over_range;
              end else begin
                GENERAL_OUTPUT_PIN_OE[g] <= 1'b0;
              end
            end
            `CG_ROLE_HIGH: begin
              GENERAL_OUTPUT_PIN_O[g] <= 1'b1;
              GENERAL_OUTPUT_PIN_OE[g] <= 1'b1;
            end
            default: begin
              GENERAL_OUTPUT_PIN_O[g] <= 1'b0;
              GENERAL_OUTPUT_PIN_OE[g] <= 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

endmodule

//--- cg_defines.vh
// register map, field positions and reset values of the codec control block
`ifndef CG_DEFINES_VH
`define CG_DEFINES_VH

`define CG_ADDR_LEFT_GAIN 8'h1c
`define CG_ADDR_RIGHT_GAIN 8'h1d
`define CG_ADDR_IRQ_CTRL 8'h1e
`define CG_ADDR_IRQ_STATUS 8'h20
`define CG_ADDR_IRQ_MASK 8'h21
`define CG_ADDR_IRQ_MODE_HI 8'h22
`define CG_ADDR_IRQ_MODE_LO 8'h23
`define CG_ADDR_MUTE_CTRL 8'h28
`define CG_ADDR_GP_FIRST 8'h29
`define CG_ADDR_GP_LAST 8'h2f
`define CG_GP_COUNT 7

`define CG_RST_GAIN 6'h00
`define CG_RST_IRQ_CTRL 8'h00
`define CG_RST_IRQ_MASK 8'h00
`define CG_RST_IRQ_MODE 8'h00
`define CG_RST_MUTE_CTRL 8'h1e
`define CG_RST_GP_CTRL 8'h00

`define CG_GAIN_MSB 5
`define CG_CTRL_ALIGN_BIT 7
`define CG_CTRL_EMPH_MSB 5
`define CG_CTRL_EMPH_LSB 4
`define CG_CTRL_STYLE_MSB 3
`define CG_CTRL_STYLE_LSB 2
`define CG_CTRL_WMASK 8'hbc

`define CG_SRC_PLL_LOSS 7
`define CG_SRC_OVER_RANGE 1
`define CG_SRC_MASK 8'h82

`define CG_MUTE_LEVEL_BIT 5
`define CG_MUTE_MAP_MSB 4
`define CG_MUTE_MAP_LSB 1
`define CG_MUTE_WMASK 8'h3e

`define CG_GP_ROLE_MSB 7
`define CG_GP_ROLE_LSB 6
`define CG_GP_LEVEL_BIT 5

`define CG_STYLE_HIGH 2'h0
`define CG_STYLE_LOW 2'h1
`define CG_STYLE_OPEN_DRAIN 2'h2

`define CG_ROLE_MUTE 2'h1
`define CG_ROLE_LOW_OVR 2'h2
`define CG_ROLE_HIGH 2'h3

`define CG_SZC_NOW 2'h0
`define CG_SZC_ZERO 2'h1
`define CG_SZC_SOFT 2'h2
`define CG_SZC_SOFT_ZERO 2'h3

`endif

//--- cg_gain_stepper.v
// applied input gain that follows its target under the soft and zero-cross setting
`timescale 1ns/1ps
`include "cg_defines.vh"

module cg_gain_stepper (
  input wire clk,
  input wire rst,
  input wire [5:0] target,
  input wire [1:0] szc_sel,
  input wire zero_cross,
  input wire ramp_tick,
  output reg [5:0] applied_reg
);

  wire up;
  wire differs;
  reg [5:0] applied_next;

  // signed compare: target above applied means step upward
  assign up = ($signed(target) > $signed(applied_reg));
  assign differs = (target != applied_reg);

  // choose between jump and single dB step per the soft/zero-cross mode
  always @* begin
    applied_next = applied_reg;
    if (differs) begin
      case (szc_sel)
        `CG_SZC_NOW: applied_next = target;
        `CG_SZC_ZERO: begin
          if (zero_cross) begin
            applied_next = target;
          end
        end
        `CG_SZC_SOFT: begin
          if (ramp_tick) begin
            applied_next = up ? applied_reg + 6'h01 : applied_reg - 6'h01;
          end
        end
        default: begin
          if (zero_cross) begin
            applied_next = up ? applied_reg + 6'h01 : applied_reg - 6'h01;
          end
        end
      endcase
    end
  end

  // applied gain register
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      applied_reg <= `CG_RST_GAIN;
    end else begin
      applied_reg <= applied_next;
    end
  end

endmodule

//--- cg_host.sv
// host model: strobe reads and writes on the register port
`timescale 1ns/1ps
module cg_host (
  input wire clk,
  input wire [7:0] rdata,
  output logic [7:0] addr,
  output logic wr,
  output logic [7:0] wdata,
  output logic rd
);
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    wdata = 8'h00;
    rd = 1'b0;
  end
  // one-cycle write strobe; stale data is inverted afterwards
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  // one-cycle read strobe; data is registered at the taking edge
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // fixed-level roles keep polarity and spare function bits clear
  function automatic logic [7:0] gp_word(input logic [1:0] role, input logic pol,
    input logic [4:0] fn);
    if (role == 2'h1)
      gp_word = {role, pol, fn};
    else if (role == 2'h2)
      gp_word = {role, 4'h0, fn[1:0]};
    else
      gp_word = {role, 6'h00};
  endfunction
endmodule

//--- cg_monitor.sv
// port-level checks on the codec control registers
`timescale 1ns/1ps
module cg_monitor (
  input wire CLK_SYS,
  input wire RST,
  input wire [7:0] REG_ADDR,
  input wire REG_WR,
  input wire [7:0] REG_WDATA,
  input wire REG_RD,
  input wire [7:0] REG_RDATA,
  input wire REG_RVALID,
  input wire [5:0] CHANNEL_MUTE,
  input wire FORCED_LOCK_ENABLE,
  input wire PORT_PHASE_ALIGN,
  input wire [1:0] EMPHASIS_FILTER_SEL,
  input wire IRQ_PIN_O,
  input wire IRQ_PIN_OE,
  input wire MUTE_INDICATOR
);
  logic [7:0] mute_reg;
  logic [5:0] mute_prev;
  logic [1:0] quiet;
  logic align_reg;
  logic all_muted;
  logic mute_exp;
  // shadow of mute and sync bits, plus a count of quiet cycles
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      mute_reg <= 8'h1e;
      mute_prev <= 6'h00;
      quiet <= 2'h0;
      align_reg <= 1'b0;
    end else begin
      mute_prev <= CHANNEL_MUTE;
      if (REG_WR && REG_ADDR == 8'h28)
        mute_reg <= REG_WDATA & 8'h3e;
      if (REG_WR && REG_ADDR == 8'h1e)
        align_reg <= REG_WDATA[7];
      if ((REG_WR && REG_ADDR == 8'h28) || CHANNEL_MUTE != mute_prev)
        quiet <= 2'h0;
      else if (quiet != 2'h3)
        quiet <= quiet + 2'h1;
    end
  end
  // an empty map counts as all muted
  assign all_muted = (~mute_reg[4] | CHANNEL_MUTE[0]) & (~mute_reg[3] | CHANNEL_MUTE[1])
    & (~mute_reg[2] | &CHANNEL_MUTE[3:2]) & (~mute_reg[1] | &CHANNEL_MUTE[5:4]);
  assign mute_exp = mute_reg[5] ? all_muted : ~all_muted;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence s_ctrl_wr;
    REG_WR && REG_ADDR == 8'h1e;
  endsequence
  a_rvalid_follows: assert property (REG_RD |=> REG_RVALID)
    else $error("read valid missing");
  a_rvalid_only: assert property (!REG_RD |=> !REG_RVALID)
    else $error("read valid without read");
  a_rdata_holds: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved");
  a_unmapped_zero: assert property (REG_RD && !(REG_ADDR inside
    {[8'h1c:8'h1e], [8'h20:8'h23], [8'h28:8'h2f]}) |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_gain_reserved: assert property (
    REG_RD && REG_ADDR inside {8'h1c, 8'h1d} |=> REG_RDATA[7:6] == 2'h0)
    else $error("gain spare bits set");
  a_align_follows: assert property (
    s_ctrl_wr ##1 !(REG_WR && REG_ADDR == 8'h1e) |=> PORT_PHASE_ALIGN == align_reg)
    else $error("alignment output wrong");
  a_emph_off: assert property (!FORCED_LOCK_ENABLE [*2] |-> EMPHASIS_FILTER_SEL == 2'h0)
    else $error("emphasis set while unlocked");
  a_irq_released: assert property (!IRQ_PIN_OE |-> !IRQ_PIN_O)
    else $error("irq pin high while released");
  a_mute_level: assert property (quiet == 2'h3 |-> MUTE_INDICATOR == mute_exp)
    else $error("mute indicator wrong");
endmodule
bind cg_control cg_monitor mon (
  .CLK_SYS(CLK_SYS), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
  .CHANNEL_MUTE(CHANNEL_MUTE), .FORCED_LOCK_ENABLE(FORCED_LOCK_ENABLE),
  .PORT_PHASE_ALIGN(PORT_PHASE_ALIGN), .EMPHASIS_FILTER_SEL(EMPHASIS_FILTER_SEL),
  .IRQ_PIN_O(IRQ_PIN_O), .IRQ_PIN_OE(IRQ_PIN_OE), .MUTE_INDICATOR(MUTE_INDICATOR)
);

//--- testbench.sv
// register-level tests of the codec control block
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end
module testbench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic pll_locked = 1'b1;
  logic ovr_left = 1'b0;
  logic ovr_right = 1'b0;
  logic [5:0] chan_mute = 6'h00;
  logic forced_lock = 1'b0;
  logic [1:0] szc = 2'h0;
  logic zero_x = 1'h0;
  logic ramp = 1'h0;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, reg_rvalid, align, irq_o, irq_oe, mute_ind;
  wire [5:0] left_gain, right_gain;
  wire [1:0] emph;
  wire [6:0] gp_o, gp_oe;
  int fail_count = 0;
  int comparisons = 0;
  logic [7:0] rst_addr [9] = '{8'h1c, 8'h1d, 8'h1e, 8'h20, 8'h21, 8'h22, 8'h23, 8'h28, 8'h29};
  logic [7:0] rst_val [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1e, 8'h00};
  logic [1:0] act [3] = '{2'b11, 2'b01, 2'b01};
  logic [1:0] idle [3] = '{2'b01, 2'b11, 2'b00};
  always #5 clk_sys = ~clk_sys;
  cg_host host (.clk(clk_sys), .rdata(reg_rdata), .addr(reg_addr), .wr(reg_wr),
    .wdata(reg_wdata), .rd(reg_rd));
  cg_control DUT (.CLK_SYS(clk_sys), .RST(rst), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
    .PLL_LOCKED(pll_locked), .ADC_OVR_LEFT(ovr_left), .ADC_OVR_RIGHT(ovr_right),
    .CHANNEL_MUTE(chan_mute), .FORCED_LOCK_ENABLE(forced_lock), .SOFT_ZERO_CROSS_SEL(szc),
    .ZERO_CROSS(zero_x), .RAMP_TICK(ramp), .LEFT_INPUT_GAIN(left_gain),
    .RIGHT_INPUT_GAIN(right_gain), .PORT_PHASE_ALIGN(align), .EMPHASIS_FILTER_SEL(emph),
    .IRQ_PIN_O(irq_o), .IRQ_PIN_OE(irq_oe), .MUTE_INDICATOR(mute_ind),
    .GENERAL_OUTPUT_PIN_O(gp_o), .GENERAL_OUTPUT_PIN_OE(gp_oe));
  task automatic settle;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.read(a, d);
    `CHK(d, e)
  endtask
  task automatic pin_chk(input logic [1:0] e);
    settle;
    `CHK({irq_o, irq_oe}, e)
  endtask
  // over-range long enough to cross the synchroniser
  task automatic ovr_pulse;
    @(posedge clk_sys) ovr_left <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ovr_left <= 1'b0;
  endtask
  // one-cycle zero-cross pulse when z is set, otherwise one ramp tick
  task automatic zx_pulse(input logic z);
    @(posedge clk_sys);
    zero_x <= z;
    ramp <= !z;
    @(posedge clk_sys);
    zero_x <= 1'h0;
    ramp <= 1'h0;
  endtask
  task automatic mute_case(input logic [7:0] m, input logic [5:0] c, input logic e);
    host.write(8'h28, m);
    @(posedge clk_sys) chan_mute <= c;
    settle;
    `CHK(mute_ind, e)
  endtask
  task automatic gp_case(input logic [7:0] w, input logic o, input logic [1:0] e);
    host.write(8'h29, w);
    @(posedge clk_sys) ovr_right <= o;
    settle;
    `CHK({gp_o[0], gp_oe[0]}, e)
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    tally_and_finish;
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (rst_addr[i]) rd_chk(rst_addr[i], rst_val[i]);
    `CHK({gp_o, gp_oe}, 14'h0000)
    host.write(8'h24, 8'h5a);
    rd_chk(8'h24, 8'h00);
    host.write(8'h1c, 8'hcf);
    host.write(8'h1d, 8'h31);
    rd_chk(8'h1c, 8'h0f);
    settle;
    `CHK(left_gain, 6'h0f)
    `CHK(right_gain, 6'h31)
    // zero-cross mode waits for the crossing, then jumps
    @(posedge clk_sys) szc <= 2'h1;
    host.write(8'h1c, 8'h05);
    settle;
    `CHK(left_gain, 6'h0f)
    zx_pulse(1'h1);
    settle;
    `CHK(left_gain, 6'h05)
    // soft mode moves one step per ramp tick
    @(posedge clk_sys) szc <= 2'h2;
    host.write(8'h1c, 8'h07);
    zx_pulse(1'h0);
    settle;
    `CHK(left_gain, 6'h06)
    // soft zero-cross mode steps on crossings; -15 toward +1 goes up
    @(posedge clk_sys) szc <= 2'h3;
    host.write(8'h1d, 8'h01);
    zx_pulse(1'h1);
    settle;
    `CHK({left_gain, right_gain}, 12'h1f2)
    @(posedge clk_sys) szc <= 2'h0;
    @(posedge clk_sys) forced_lock <= 1'b1;
    for (int c = 1; c < 4; c++) begin
      host.write(8'h1e, 8'h80 | 8'(c << 4));
      settle;
      `CHK(emph, 2'(c))
    end
    `CHK(align, 1'b1)
    rd_chk(8'h1e, 8'hb0);
    @(posedge clk_sys) forced_lock <= 1'b0;
    settle;
    `CHK(emph, 2'h0)
    host.write(8'h21, 8'h82);
    for (int s = 0; s < 3; s++) begin
      host.write(8'h1e, 8'(s << 2));
      ovr_pulse;
      pin_chk(act[s]);
      rd_chk(8'h20, 8'h02);
      pin_chk(idle[s]);
      rd_chk(8'h20, 8'h00);
    end
    host.write(8'h1e, 8'h0c);
    pin_chk(2'b00);
    host.write(8'h1e, 8'h00);
    host.write(8'h21, 8'h80);
    ovr_pulse;
    pin_chk(2'b01);
    rd_chk(8'h20, 8'h00);
    @(posedge clk_sys) pll_locked <= 1'b0;
    pin_chk(2'b11);
    @(posedge clk_sys) pll_locked <= 1'b1;
    rd_chk(8'h20, 8'h80);
    host.write(8'h21, 8'h82);
    host.write(8'h23, 8'h02);
    @(posedge clk_sys) ovr_left <= 1'b1;
    pin_chk(2'b01);
    @(posedge clk_sys) ovr_left <= 1'b0;
    pin_chk(2'b11);
    rd_chk(8'h20, 8'h02);
    host.write(8'h23, 8'h00);
    host.write(8'h22, 8'h02);
    @(posedge clk_sys) ovr_left <= 1'b1;
    pin_chk(2'b11);
    rd_chk(8'h20, 8'h02);
    pin_chk(2'b11);
    @(posedge clk_sys) ovr_left <= 1'b0;
    pin_chk(2'b01);
    rd_chk(8'h20, 8'h02);
    host.write(8'h23, 8'h02);
    ovr_pulse;
    pin_chk(2'b01);
    rd_chk(8'h20, 8'h00);
    mute_case(8'h1e, 6'h3f, 1'b0);
    mute_case(8'h1e, 6'h3e, 1'b1);
    mute_case(8'h04, 6'h3e, 1'b0);
    mute_case(8'h04, 6'h3a, 1'b1);
    mute_case(8'h20, 6'h00, 1'b1);
    mute_case(8'h3e, 6'h3f, 1'b1);
    gp_case(host.gp_word(2'h1, 1'b1, 5'h1e), 1'b0, 2'b11);
    gp_case(host.gp_word(2'h1, 1'b0, 5'h1e), 1'b0, 2'b01);
    gp_case(host.gp_word(2'h2, 1'b0, 5'h00), 1'b0, 2'b01);
    gp_case(host.gp_word(2'h2, 1'b0, 5'h03), 1'b0, 2'b00);
    gp_case(host.gp_word(2'h2, 1'b0, 5'h03), 1'b1, 2'b01);
    gp_case(8'he0, 1'b0, 2'b11);
    rd_chk(8'h29, 8'he0);
    for (int i = 0; i < 7; i++) host.write(8'h29 + 8'(i), 8'hc0);
    settle;
    `CHK(gp_o, 7'h7f)
    `CHK(gp_oe, 7'h7f)
    // second reset in mid-run restores every default
    @(posedge clk_sys) rst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
    foreach (rst_addr[i]) rd_chk(rst_addr[i], rst_val[i]);
    `CHK({left_gain, right_gain, gp_o, gp_oe}, 26'h0000000)
    tally_and_finish;
  end
endmodule
